// [mbm_pkg.sv]
// Purpose: shared constants and types for the drive network data map
// Assumes: requests arrive already decoded from the serial link, one per clock
// Notes: coil map bits are indexed as coil address minus the first mapped coil
package mbm_pkg;

	// ==========================================
	// coil address space
	localparam logic [15:0] COIL_TERM_FIRST = 16'h0007;
	localparam logic [15:0] COIL_TERM_LAST = 16'h000d;
	localparam logic [15:0] COIL_MAP_FIRST = 16'h002d;
	localparam logic [15:0] COIL_MAP_LAST = 16'h0058;
	localparam int TERM_N = 7;
	localparam int ERR_N = 5;
	localparam int COIL_MAP_W = 44;
	// reserved coils inside the mapped range always read zero
	localparam logic [43:0] COIL_RSV_MASK = 44'h424_00e0_1c18;

	// comm error flag positions (crc sits at the lowest coil)
	localparam int ERR_CRC = 0;
	localparam int ERR_OVERRUN = 1;
	localparam int ERR_FRAMING = 2;
	localparam int ERR_PARITY = 3;
	localparam int ERR_SUM = 4;

	// ==========================================
	// holding register space
	localparam logic [15:0] REG_SETPOINT_HIGH = 16'h0001;
	localparam logic [15:0] REG_SETPOINT_LOW = 16'h0002;
	localparam logic [15:0] REG_STATE_DETAILED = 16'h0003;
	localparam logic [15:0] REG_STATE_COARSE = 16'h0004;
	localparam logic [15:0] REG_MOTION_PHASE = 16'h0005;
	localparam logic [15:0] REG_LOOP_FEEDBACK = 16'h0006;
	localparam logic [15:0] REG_RSV_LAST = 16'h0010;

	// ==========================================
	// ranges, scaling and reset values
	localparam logic [31:0] SETPOINT_MAX = 32'h0000_9c40;
	localparam logic [15:0] FEEDBACK_MAX = 16'h2710;
	localparam logic [7:0] FREQ_SRC_NETWORK = 8'h03;
	localparam int SCALE_FREQ = 100;
	localparam int SCALE_FEEDBACK = 100;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [31:0] DWORD_RST = 32'h0000_0000;

	// ==========================================
	// drive status word encodings
	typedef enum logic [15:0] {
		SA_INITIAL = 16'h0000, SA_STOPPING = 16'h0002, SA_RUNNING = 16'h0003,
		SA_FREE_RUN = 16'h0004, SA_JOGGING = 16'h0005, SA_DC_BRAKE = 16'h0006,
		SA_RETRYING = 16'h0007, SA_TRIPPING = 16'h0008, SA_UNDERVOLT = 16'h0009
	} mbm_state_detailed_t;

	typedef enum logic [15:0] {
		SB_STOPPING = 16'h0000, SB_RUNNING = 16'h0001, SB_TRIPPING = 16'h0002
	} mbm_state_coarse_t;

	typedef enum logic [15:0] {
		SC_STOPPING = 16'h0001, SC_DECEL = 16'h0002, SC_CONSTANT = 16'h0003,
		SC_ACCEL = 16'h0004, SC_FORWARD = 16'h0005, SC_REVERSE = 16'h0006,
		SC_FWD_TO_REV = 16'h0007, SC_REV_TO_FWD = 16'h0008,
		SC_START_FWD = 16'h0009, SC_START_REV = 16'h000a
	} mbm_motion_phase_t;

	// ==========================================
	// live drive flags, highest coil first, laid out as the coil map
	typedef struct packed {
		logic gate_monitor;
		logic rsv_57;
		logic second_motor_select_flag;
		logic run_cmd_source_flag;
		logic freq_cmd_source_flag;
		logic option_loss;
		logic rsv_52;
		logic window_oi;
		logic window_o;
		logic rsv_4f;
		logic [4:0] comm_err;
		logic write_busy;
		logic major_failure_flag;
		logic reverse_run;
		logic forward_run;
		logic drive_ready_flag;
		logic [2:0] rsv_44_42;
		logic [2:0] general_out;
		logic low_current;
		logic sink_hot;
		logic start_contact;
		logic fan_slow;
		logic capacitor_life;
		logic [2:0] rsv_39_37;
		logic logic_result_three;
		logic logic_result_two;
		logic logic_result_one;
		logic comm_line_loss_flag;
		logic feedback_compare;
		logic [1:0] rsv_31_30;
		logic analog_oi_loss;
		logic analog_o_loss;
		logic overload_advance_notice_two;
	} mbm_coils_t;

	// host request and answer
	typedef struct packed {
		logic valid;
		logic coil;
		logic write;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mbm_req_t;

	typedef struct packed {
		logic ack;
		logic refused;
		logic [15:0] rdata;
	} mbm_rsp_t;

	// whole state of the map
	typedef struct packed {
		mbm_rsp_t rsp;
		logic [TERM_N-1:0] term_coil;
		logic [TERM_N-1:0] term_prev;
		logic [TERM_N-1:0] term_active;
		logic [ERR_N-1:0] comm_err;
		logic [15:0] pending_high;
		logic [31:0] setpoint;
		logic setpoint_active;
		logic [15:0] feedback;
	} mbm_state_t;

endpackage

// [mbm_scale.sv]
// Purpose: split a network integer into whole units and remainder
// Assumes: factor is a small constant, value never needs more than 32 bits
// Notes: one clock of latency, outputs registered
`timescale 1ns/1ps
module mbm_scale #(
	parameter int FACTOR = 100
) (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// scaled network value
	input wire logic [31:0] value,
	// engineering value
	output logic [31:0] whole_ff,
	output logic [7:0] frac_ff
);

	// ==========================================
	// constant divide
	logic [31:0] nxt_whole;
	logic [31:0] nxt_rem;

	// divisor is a constant so this folds to fixed logic
	always_comb begin
		nxt_whole = value / 32'(FACTOR);
		nxt_rem = value % 32'(FACTOR);
	end

	// register the result
	always_ff @(posedge clock) begin
		if (!rstn) begin
			whole_ff <= mbm_pkg::DWORD_RST;
			frac_ff <= mbm_pkg::WORD_RST[7:0];
		end else begin
			whole_ff <= nxt_whole;
			frac_ff <= nxt_rem[7:0];
		end
	end

endmodule

// [mbm_map.sv]
// Purpose: network coil and holding register map of the drive
// Assumes: one decoded request per clock, answered on the next clock
// Notes: coils below the terminal range and trip history live elsewhere
`timescale 1ns/1ps
module mbm_map (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// host request and answer
	input wire mbm_pkg::mbm_req_t req,
	output mbm_pkg::mbm_rsp_t rsp_ff,
	// live drive status
	input wire mbm_pkg::mbm_coils_t live,
	input wire mbm_pkg::mbm_state_detailed_t state_detailed,
	input wire mbm_pkg::mbm_state_coarse_t state_coarse,
	input wire mbm_pkg::mbm_motion_phase_t motion_phase,
	input wire logic [7:0] frequency_source_select,
	// control terminal block
	input wire logic [mbm_pkg::TERM_N-1:0] term_in,
	output logic [mbm_pkg::TERM_N-1:0] term_active_ff,
	// receiver error events and reset command
	input wire logic [mbm_pkg::ERR_N-1:0] comm_err_evt,
	input wire logic err_reset,
	output logic [mbm_pkg::ERR_N-1:0] comm_err_ff,
	// setpoint and feedback to the drive core
	output logic setpoint_active_ff,
	output logic [31:0] setpoint_hz_ff,
	output logic [7:0] setpoint_centi_ff,
	output logic [31:0] feedback_pct_ff,
	output logic [7:0] feedback_centi_ff
);

	// ==========================================
	// state
	mbm_pkg::mbm_state_t st_ff;
	mbm_pkg::mbm_state_t nxt_st;
	mbm_pkg::mbm_coils_t coil_view;
	logic [mbm_pkg::COIL_MAP_W-1:0] coil_vec;
	logic [15:0] coil_idx;
	logic [15:0] term_idx;
	logic [mbm_pkg::TERM_N-1:0] term_fall;
	logic [mbm_pkg::TERM_N-1:0] term_wr;
	logic [mbm_pkg::TERM_N-1:0] term_view;
	logic [31:0] new_setpoint;
	logic in_term;
	logic in_map;
	logic hit;
	logic bad;
	logic [15:0] rd;

	// ==========================================
	// coil view: live flags with internal flags overlaid
	always_comb begin
		coil_view = live;
		coil_view.comm_err = st_ff.comm_err;
		coil_vec = coil_view & ~mbm_pkg::COIL_RSV_MASK;
		coil_idx = req.addr - mbm_pkg::COIL_MAP_FIRST;
		term_idx = req.addr - mbm_pkg::COIL_TERM_FIRST;
		in_term = req.addr >= mbm_pkg::COIL_TERM_FIRST && req.addr <= mbm_pkg::COIL_TERM_LAST;
		in_map = req.addr >= mbm_pkg::COIL_MAP_FIRST && req.addr <= mbm_pkg::COIL_MAP_LAST;
		term_view = st_ff.term_coil | term_in;
	end

	// per terminal: falling edge and coil write strobe
	genvar g;
	generate
		for (g = 0; g < mbm_pkg::TERM_N; g++) begin : g_term
			assign term_fall[g] = st_ff.term_prev[g] & ~term_in[g];
			assign term_wr[g] = req.valid && req.coil && req.write && in_term
				&& term_idx == 16'(g);
		end
	endgenerate

	// ==========================================
	// request decode and next state
	always_comb begin
		nxt_st = st_ff;
		hit = 1'b0;
		bad = 1'b0;
		rd = mbm_pkg::WORD_RST;
		new_setpoint = {st_ff.pending_high, req.wdata};

		// coil space
		if (req.valid && req.coil) begin
			if (in_term) begin
				hit = 1'b1;
				rd = {15'h0000, term_view[term_idx[2:0]]};
			end else if (in_map) begin
				hit = 1'b1;
				rd = {15'h0000, coil_vec[coil_idx[5:0]]};
				bad = req.write;
			end
		end

		// holding register space
		if (req.valid && !req.coil) begin
			unique case (req.addr)
				mbm_pkg::REG_SETPOINT_HIGH: begin
					hit = 1'b1;
					rd = st_ff.setpoint[31:16];
					if (req.write) begin
						nxt_st.pending_high = req.wdata;
					end
				end
				mbm_pkg::REG_SETPOINT_LOW: begin
					hit = 1'b1;
					rd = st_ff.setpoint[15:0];
					if (req.write) begin
						if (new_setpoint > mbm_pkg::SETPOINT_MAX) begin
							bad = 1'b1;
						end else begin
							nxt_st.setpoint = new_setpoint;
						end
					end
				end
				mbm_pkg::REG_STATE_DETAILED: begin
					hit = 1'b1;
					rd = state_detailed;
					bad = req.write;
				end
				mbm_pkg::REG_STATE_COARSE: begin
					hit = 1'b1;
					rd = state_coarse;
					bad = req.write;
				end
				mbm_pkg::REG_MOTION_PHASE: begin
					hit = 1'b1;
					rd = motion_phase;
					bad = req.write;
				end
				mbm_pkg::REG_LOOP_FEEDBACK: begin
					hit = 1'b1;
					rd = st_ff.feedback;
					if (req.write) begin
						if (req.wdata > mbm_pkg::FEEDBACK_MAX) begin
							bad = 1'b1;
						end else begin
							nxt_st.feedback = req.wdata;
						end
					end
				end
				default: begin
					// reserved block reads zero and refuses writes
					if (req.addr > mbm_pkg::REG_MOTION_PHASE
						&& req.addr <= mbm_pkg::REG_RSV_LAST) begin
						hit = 1'b1;
						bad = req.write;
					end
				end
			endcase
		end

		// answer: address zero and unmapped addresses are refused
		nxt_st.rsp.ack = req.valid;
		nxt_st.rsp.refused = req.valid && (!hit || bad);
		nxt_st.rsp.rdata = (hit && !bad && !req.write) ? rd : mbm_pkg::WORD_RST;

		// terminal coils: falling terminal edge beats a same-cycle write
		nxt_st.term_prev = term_in;
		for (int i = 0; i < mbm_pkg::TERM_N; i++) begin
			if (term_fall[i]) begin
				nxt_st.term_coil[i] = 1'b0;
			end else if (term_wr[i]) begin
				nxt_st.term_coil[i] = req.wdata[0];
			end
		end
		nxt_st.term_active = nxt_st.term_coil | term_in;

		// sticky receive errors: a new error wins over the reset
		nxt_st.comm_err = (err_reset ? '0 : st_ff.comm_err) | comm_err_evt;

		// setpoint is flagged active only while the network owns the frequency; setpoint_hz_ff follows it at all times
		nxt_st.setpoint_active = frequency_source_select == mbm_pkg::FREQ_SRC_NETWORK;
	end

	// ==========================================
	// state register
	always_ff @(posedge clock) begin
		if (!rstn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================
	// outputs straight from the state register
	always_comb begin
		rsp_ff = st_ff.rsp;
		term_active_ff = st_ff.term_active;
		comm_err_ff = st_ff.comm_err;
		setpoint_active_ff = st_ff.setpoint_active;
	end

	// ==========================================
	// decimal point placement for the core
	mbm_scale #(
		.FACTOR(mbm_pkg::SCALE_FREQ)
	) u_freq_scale (
		.clock(clock),
		.rstn(rstn),
		.value(st_ff.setpoint),
		.whole_ff(setpoint_hz_ff),
		.frac_ff(setpoint_centi_ff)
	);

	mbm_scale #(
		.FACTOR(mbm_pkg::SCALE_FEEDBACK)
	) u_fb_scale (
		.clock(clock),
		.rstn(rstn),
		.value({16'h0000, st_ff.feedback}),
		.whole_ff(feedback_pct_ff),
		.frac_ff(feedback_centi_ff)
	);

endmodule

// [mbm_map_checker.sv]
// Purpose: port checks for the drive data map
// Assumes: one clock, synchronous active low reset
// Notes: bound to mbm_map
`timescale 1ns/1ps
module mbm_map_checker (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// host side
	input wire mbm_pkg::mbm_req_t req,
	input wire mbm_pkg::mbm_rsp_t rsp_ff,
	// drive side
	input wire logic [mbm_pkg::TERM_N-1:0] term_in,
	input wire logic [mbm_pkg::TERM_N-1:0] term_active_ff,
	input wire logic [mbm_pkg::ERR_N-1:0] comm_err_evt,
	input wire logic err_reset,
	input wire logic [mbm_pkg::ERR_N-1:0] comm_err_ff,
	input wire logic [7:0] frequency_source_select,
	input wire logic setpoint_active_ff
);
	// ====
	// assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	// terminal 0 falls, then stays off with no coil write
	sequence s_fall;
		term_in[0] ##1 !term_in[0];
	endsequence
	sequence s_quiet;
		(!term_in[0] && !(req.valid && req.write && req.coil && req.addr == 16'h0007))[*2];
	endsequence
	AST_ACK: assert property (req.valid |=> rsp_ff.ack)
		else $error("request not answered");
	AST_ZERO: assert property (req.valid && req.addr == 16'h0000 |=> rsp_ff.refused)
		else $error("address zero not refused");
	AST_RO_WRITE: assert property (req.valid && req.write && (req.coil ? (req.addr >= 16'h002d
		&& req.addr <= 16'h0058) : req.addr inside {16'h0003, 16'h0004, 16'h0005})
		|=> rsp_ff.refused && rsp_ff.rdata == 16'h0000)
		else $error("read-only write accepted");
	AST_ERR_SET: assert property (comm_err_evt != 0 |=>
		(comm_err_ff & $past(comm_err_evt)) == $past(comm_err_evt))
		else $error("error flag not set");
	AST_ERR_HOLD: assert property (!err_reset |=>
		(comm_err_ff & $past(comm_err_ff)) == $past(comm_err_ff))
		else $error("error flag lost");
	AST_ERR_CLR: assert property (err_reset && comm_err_evt == 0 |=> comm_err_ff == 0)
		else $error("error flags not cleared");
	AST_TERM_WIN: assert property (term_in != 0 |=>
		(term_active_ff & $past(term_in)) == $past(term_in))
		else $error("terminal not active");
	AST_TERM_CLR: assert property (s_fall ##0 s_quiet |=> !term_active_ff[0])
		else $error("terminal coil not cleared");
	AST_SRC: assert property (1'b1 |=>
		setpoint_active_ff == ($past(frequency_source_select) == 8'h03))
		else $error("setpoint source flag wrong");
endmodule
bind mbm_map mbm_map_checker u_chk (.clock(clock), .rstn(rstn), .req(req), .rsp_ff(rsp_ff),
	.term_in(term_in), .term_active_ff(term_active_ff), .comm_err_evt(comm_err_evt),
	.err_reset(err_reset), .comm_err_ff(comm_err_ff),
	.frequency_source_select(frequency_source_select), .setpoint_active_ff(setpoint_active_ff));

// [mbm_host.sv]
// Purpose: network master model issuing map requests
// Assumes: tasks are entered two ns after a rising edge
// Notes: idle lines show the inverse of the last address and data
`timescale 1ns/1ps
module mbm_host (
	// clock
	input wire logic clock,
	// request to the map
	output mbm_pkg::mbm_req_t req
);
	logic [16:0] exp_q[$];
	initial req = '0;
	// one request held over its taking edge, expected answer noted
	task automatic xfer(input logic c, w, input logic [15:0] a, d, input logic [16:0] e);
		exp_q.push_back(e);
		req = {1'b1, c, w, a, d};
		@(posedge clock);
		#2;
	endtask
	// release the request lines for one cycle
	task automatic idle();
		req = {1'b0, req.coil, req.write, ~req.addr, ~req.wdata};
		@(posedge clock);
		#2;
	endtask
	// scale an engineering frequency, high word first
	task automatic set_freq(input int hz, ch, input logic rf);
		logic [31:0] v;
		v = 32'(hz * mbm_pkg::SCALE_FREQ + ch);
		xfer(1'b0, 1'b1, mbm_pkg::REG_SETPOINT_HIGH, v[31:16], 17'h0);
		xfer(1'b0, 1'b1, mbm_pkg::REG_SETPOINT_LOW, v[15:0], {rf, 16'h0});
	endtask
endmodule

// [testbench.sv]
// Purpose: self-checking bench for the drive data map
// Assumes: host model drives requests two ns after rising edges
// Notes: answers are matched with notes queued by the host
`timescale 1ns/1ps
module testbench;
	// ====
	// wiring and counters
	logic clock, rstn, err_reset, sp_act, b;
	logic [4:0] evt, err_ff;
	logic [6:0] term_in, term_act;
	logic [7:0] fss, hzc, pctc;
	logic [31:0] hz, pct, v, seed;
	logic [43:0] live;
	logic [17:0] bad [6] = '{18'h2_0000, 18'h2_0059, 18'h3_0034, 18'h0_0000, 18'h0_0011,
		18'h1_0004};
	mbm_pkg::mbm_req_t req;
	mbm_pkg::mbm_rsp_t rsp;
	mbm_pkg::mbm_state_detailed_t sd;
	mbm_pkg::mbm_state_coarse_t sc;
	mbm_pkg::mbm_motion_phase_t mp;
	int checks, fail_count;
	mbm_map u_dut (.clock(clock), .rstn(rstn), .req(req), .rsp_ff(rsp), .live(live),
		.state_detailed(sd), .state_coarse(sc), .motion_phase(mp),
		.frequency_source_select(fss), .term_in(term_in), .term_active_ff(term_act),
		.comm_err_evt(evt), .err_reset(err_reset), .comm_err_ff(err_ff),
		.setpoint_active_ff(sp_act), .setpoint_hz_ff(hz), .setpoint_centi_ff(hzc),
		.feedback_pct_ff(pct), .feedback_centi_ff(pctc));
	mbm_host u_host (.clock(clock), .req(req));
	// 50 ns clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// lfsr random source
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	// compare and count
	task automatic cmp(input logic [39:0] got, exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// print counts and verdict, then stop
	task automatic summarize();
		cmp(40'(u_host.exp_q.size()), 40'h0);
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// read the five error coils
	task automatic err_reads(input logic e);
		for (int k = 0; k < 5; k++)
			u_host.xfer(1'b1, 1'b0, 16'h004a + 16'(k), 16'h0, {16'h0, e});
		u_host.idle();
	endtask
	// match each answer with the oldest note
	always @(negedge clock) begin
		if (rstn === 1'b1 && rsp.ack === 1'b1) begin
			if (u_host.exp_q.size() == 0) cmp(40'h1, 40'h0);
			else cmp({rsp.refused, rsp.rdata}, u_host.exp_q.pop_front());
		end
	end
	// hang guard
	initial begin
		repeat (3000) @(posedge clock);
		cmp(40'h1, 40'h0);
		summarize();
	end
	// main sequence
	initial begin
		seed = 32'd84666;
		{rstn, err_reset, evt, term_in, fss, live} = '0;
		sd = mbm_pkg::SA_INITIAL;
		sc = mbm_pkg::SB_RUNNING;
		mp = mbm_pkg::SC_STOPPING;
		repeat (8) @(posedge clock);
		#2;
		rstn = 1'b1;
		v = rnd();
		live = {v[11:0], rnd()};
		for (int i = 0; i < 44; i++) begin
			b = live[i] & ~mbm_pkg::COIL_RSV_MASK[i] & (i < 29 || i > 33);
			u_host.xfer(1'b1, 1'b0, 16'h002d + 16'(i), 16'h0, {16'h0, b});
		end
		for (int k = 0; k < 6; k++)
			u_host.xfer(bad[k][17], bad[k][16], bad[k][15:0], 16'hffff, 17'h1_0000);
		u_host.xfer(1'b0, 1'b0, 16'h0007, 16'h0, 17'h0);
		u_host.xfer(1'b0, 1'b1, 16'h0010, 16'h1234, 17'h1_0000);
		evt = 5'h1f;
		u_host.idle();
		evt = 5'h00;
		err_reads(1'b1);
		err_reset = 1'b1;
		u_host.idle();
		err_reset = 1'b0;
		err_reads(1'b0);
		term_in = 7'h01;
		u_host.xfer(1'b1, 1'b1, 16'h0007, 16'h0, 17'h0);
		u_host.xfer(1'b1, 1'b0, 16'h0007, 16'h0, 17'h1);
		term_in = 7'h00;
		// let the terminal's falling edge pass, it would beat a same-cycle coil write
		u_host.idle();
		u_host.xfer(1'b1, 1'b1, 16'h0007, 16'h1, 17'h0);
		u_host.xfer(1'b1, 1'b0, 16'h0007, 16'h0, 17'h1);
		term_in = 7'h01;
		u_host.idle();
		term_in = 7'h00;
		u_host.idle();
		u_host.xfer(1'b1, 1'b0, 16'h0007, 16'h0, 17'h0);
		cmp(40'(sp_act), 40'h0);
		fss = mbm_pkg::FREQ_SRC_NETWORK;
		v = rnd() % 40001;
		u_host.set_freq(int'(v / 100), int'(v % 100), 1'b0);
		u_host.xfer(1'b0, 1'b0, 16'h0001, 16'h0, {1'b0, v[31:16]});
		u_host.xfer(1'b0, 1'b0, 16'h0002, 16'h0, {1'b0, v[15:0]});
		u_host.idle();
		cmp({hz, hzc}, {v / 100, 8'(v % 100)});
		cmp(40'(sp_act), 40'h1);
		u_host.set_freq(400, 1, 1'b1);
		u_host.set_freq(400, 0, 1'b0);
		u_host.xfer(1'b0, 1'b1, 16'h0006, 16'd10001, 17'h1_0000);
		u_host.xfer(1'b0, 1'b1, 16'h0006, 16'd10000, 17'h0);
		u_host.xfer(1'b0, 1'b0, 16'h0006, 16'h0, 17'd10000);
		for (int k = 0; k < 10; k++) begin
			u_host.xfer(1'b0, 1'b0, 16'h0003, 16'h0, {1'b0, sd});
			u_host.xfer(1'b0, 1'b0, 16'h0004, 16'h0, {1'b0, sc});
			u_host.xfer(1'b0, 1'b0, 16'h0005, 16'h0, {1'b0, mp});
			sd = sd.next();
			sc = sc.next();
			mp = mp.next();
		end
		u_host.idle();
		cmp({hz, hzc}, {32'd400, 8'd0});
		cmp({pct, pctc}, {32'd100, 8'd0});
		cmp({term_act, err_ff}, 12'h0);
		summarize();
	end
endmodule
